// ==== bench/dscp_frame_sink.sv ====
// downstream rewriter model: collects finished frames
`timescale 1ns/1ps
module dscp_frame_sink (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // egress result
  input wire logic i_valid,
  input wire logic [7:0] i_tos,
  input wire logic [15:0] i_csum,
  input wire logic i_written
);
  logic [24:0] rx[$];
  always @(posedge i_clk) begin
    if (i_nrst === 1'b1 && i_valid === 1'b1) begin
      rx.push_back({i_written, i_tos, i_csum});
    end
  end
endmodule : dscp_frame_sink

// ==== bench/dscp_remark_top_tb.sv ====
// self-checking bench for the codepoint remark pipeline
`timescale 1ns/1ps
module dscp_remark_top_tb;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic i_in_valid = 1'b0;
  logic [2:0] i_in_port = 3'h0;
  logic [2:0] i_egr_port = 3'h0;
  logic [1:0] i_in_kind = 2'h0;
  logic [2:0] i_in_class = 3'h0;
  logic i_in_dp = 1'b0;
  logic [7:0] i_in_tos = 8'h00;
  logic [15:0] i_in_csum = 16'h0000;
  logic i_cls_hit = 1'b0;
  logic i_cls_cp_ena = 1'b0;
  logic [5:0] i_cls_cp = 6'h00;
  logic o_out_valid;
  logic [7:0] o_out_tos;
  logic [15:0] o_out_csum;
  logic o_out_written;
  int miscompares = 0;
  int total_checks = 0;
  integer seed;
  logic [15:0] mode;
  logic [7:0] egr;
  logic [63:0] cp_sel;
  logic trans;
  logic [5:0] map_t[16];
  logic [5:0] dp0_t[64];
  logic [5:0] dp1_t[64];
  logic [24:0] expq[$];
  logic [31:0] rd;
  logic er;
  logic [31:0] r;
  logic [24:0] g;
  logic [24:0] e;
  logic [15:0] wcnt = 16'h0000;
  always #10 i_clk = ~i_clk;
  dscp_remark_top i_dscp_remark_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_in_valid(i_in_valid), .i_in_port(i_in_port),
    .i_egr_port(i_egr_port), .i_in_kind(i_in_kind), .i_in_class(i_in_class), .i_in_dp(i_in_dp),
    .i_in_tos(i_in_tos), .i_in_csum(i_in_csum), .i_cls_hit(i_cls_hit), .i_cls_cp_ena(i_cls_cp_ena),
    .i_cls_cp(i_cls_cp), .o_out_valid(o_out_valid), .o_out_tos(o_out_tos), .o_out_csum(o_out_csum),
    .o_out_written(o_out_written));
  dscp_frame_sink i_dscp_frame_sink (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(o_out_valid), .i_tos(o_out_tos),
    .i_csum(o_out_csum), .i_written(o_out_written));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_frame(input logic [24:0] got, input logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_frame
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  function automatic logic [24:0] expect_frame(logic [2:0] ip, logic [2:0] ep, logic [1:0] k, logic [2:0] c,
    logic dp, logic [7:0] tos, logic [15:0] cs, logic hit, logic cena, logic [5:0] ccp);
    logic sel;
    logic [5:0] v;
    logic [31:0] s;
    case (mode[2*ip +: 2])
      dscp_remark_pkg::MODE_NONE: sel = 1'b0;
      dscp_remark_pkg::MODE_ZERO: sel = (tos[7:2] == 6'h00);
      dscp_remark_pkg::MODE_SELECT: sel = cp_sel[tos[7:2]];
      default: sel = 1'b1;
    endcase
    v = map_t[{dp, c}];
    if (hit && cena) begin
      sel = 1'b1;
      v = ccp;
    end
    if (trans) v = dp ? dp1_t[v] : dp0_t[v];
    if (!(sel && egr[ep] && (k == dscp_remark_pkg::KIND_IPV4 || k == dscp_remark_pkg::KIND_IPV6))) begin
      return {1'b0, tos, cs};
    end
    if (k == dscp_remark_pkg::KIND_IPV4) begin
      s = {16'h0, ~cs} + {16'h0, ~{8'h00, tos}} + {24'h0, v, tos[1:0]};
      s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      cs = ~s[15:0];
    end
    return {1'b1, v, tos[1:0], cs};
  endfunction : expect_frame
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #(20 * 40000);
    miscompares++;
    finish_test();
  end
  initial begin
    seed = 32'h6843;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    apb(1'b0, dscp_remark_pkg::ADDR_MODE, 32'h0);
    chk(rd, {16'h0, dscp_remark_pkg::RST_MODE});
    apb(1'b0, dscp_remark_pkg::ADDR_EGR_ENA, 32'h0);
    chk(rd, {24'h0, dscp_remark_pkg::RST_EGR_ENA});
    apb(1'b1, 12'h0f0, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int i = 0; i < 64; i++) begin
      dp0_t[i] = 6'($random(seed));
      dp1_t[i] = 6'($random(seed));
      apb(1'b1, dscp_remark_pkg::ADDR_DP0_BASE + 12'(4 * i), {26'h0, dp0_t[i]});
      apb(1'b1, dscp_remark_pkg::ADDR_DP1_BASE + 12'(4 * i), {26'h0, dp1_t[i]});
      if (i < 16) map_t[i] = 6'($random(seed));
      if (i < 16) apb(1'b1, dscp_remark_pkg::ADDR_MAP_BASE + 12'(4 * i), {26'h0, map_t[i]});
    end
    for (int p = 0; p < 4; p++) begin
      mode = (p == 0) ? 16'he4e4 : 16'($random(seed));
      egr = (p == 0) ? 8'hff : 8'($random(seed));
      cp_sel = {32'($random(seed)), 32'($random(seed))};
      trans = p[0];
      apb(1'b1, dscp_remark_pkg::ADDR_MODE, {16'h0, mode});
      apb(1'b1, dscp_remark_pkg::ADDR_EGR_ENA, {24'h0, egr});
      apb(1'b1, dscp_remark_pkg::ADDR_SEL_LO, cp_sel[31:0]);
      apb(1'b1, dscp_remark_pkg::ADDR_SEL_HI, cp_sel[63:32]);
      apb(1'b1, dscp_remark_pkg::ADDR_TRANS_CTL, {31'h0, trans});
      apb(1'b0, dscp_remark_pkg::ADDR_MODE, 32'h0);
      chk(rd, {16'h0, mode});
      for (int n = 0; n < 200; n++) begin
        @(posedge i_clk);
        r = $random(seed);
        i_in_valid <= 1'b1;
        i_in_port <= r[2:0];
        i_egr_port <= r[5:3];
        i_in_kind <= r[7:6];
        i_in_class <= r[10:8];
        i_in_dp <= r[11];
        i_in_tos <= {(r[13:12] == 2'h0) ? 6'h00 : r[19:14], r[21:20]};
        i_in_csum <= 16'($random(seed));
        i_cls_hit <= r[22];
        i_cls_cp_ena <= r[23];
        i_cls_cp <= r[29:24];
        #1;
        expq.push_back(expect_frame(i_in_port, i_egr_port, i_in_kind, i_in_class, i_in_dp, i_in_tos, i_in_csum,
          i_cls_hit, i_cls_cp_ena, i_cls_cp));
      end
      @(posedge i_clk);
      i_in_valid <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_ce <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_pready}, 32'h0);
      i_ce <= 1'b1;
    end
    chk(32'(i_dscp_frame_sink.rx.size()), 32'(expq.size()));
    while (expq.size() > 0 && i_dscp_frame_sink.rx.size() > 0) begin
      g = i_dscp_frame_sink.rx.pop_front();
      e = expq.pop_front();
      wcnt = wcnt + {15'h0000, e[24]};
      chk_frame(g & 25'h1000000, e & 25'h1000000);
      chk_frame(g & 25'h0ff0000, e & 25'h0ff0000);
      chk_frame(g & 25'h000ffff, e & 25'h000ffff);
    end
    apb(1'b0, dscp_remark_pkg::ADDR_STATUS, 32'h0);
    chk(rd, {wcnt, 16'h0320});
    finish_test();
  end
endmodule : dscp_remark_top_tb

// ==== hdl/dscp_egress_write.sv ====
// egress stage: gate, translate, write codepoint, fix checksum
`timescale 1ns/1ps
module dscp_egress_write (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // configuration
  input wire logic i_port_ena,
  input wire logic i_trans_ena,
  input wire logic [5:0] i_dp0_cp,
  input wire logic [5:0] i_dp1_cp,
  // carried frame
  input wire logic i_valid,
  input wire logic [1:0] i_kind,
  input wire logic i_dp,
  input wire logic i_rewrite,
  input wire logic [5:0] i_new_cp,
  input wire logic [7:0] i_tos,
  input wire logic [15:0] i_csum,
  // result
  output logic o_valid,
  output logic [7:0] o_tos,
  output logic [15:0] o_csum,
  output logic o_written
);
  logic is_ip;
  logic do_write;
  logic [5:0] cp_out;
  logic [7:0] tos_new;

  // ones-complement checksum update for a changed 16-bit word
  function automatic logic [15:0] csum_fix(input logic [15:0] hc, input logic [15:0] m_old,
                                           input logic [15:0] m_new);
    logic [16:0] s;
    s = {1'b0, ~hc} + {1'b0, ~m_old};
    s = {1'b0, s[15:0]} + {16'h0000, s[16]};
    s = {1'b0, s[15:0]} + {1'b0, m_new};
    s = {1'b0, s[15:0]} + {16'h0000, s[16]};
    csum_fix = ~s[15:0];
  endfunction : csum_fix

  assign is_ip = (i_kind == dscp_remark_pkg::KIND_IPV4) || (i_kind == dscp_remark_pkg::KIND_IPV6);
  assign do_write = is_ip && i_rewrite && i_port_ena;
  assign cp_out = !i_trans_ena ? i_new_cp : (i_dp ? i_dp1_cp : i_dp0_cp);
  assign tos_new = {cp_out, i_tos[1:0]};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_tos <= 8'h00;
      o_csum <= 16'h0000;
      o_written <= 1'b0;
    end else if (i_ce) begin
      o_valid <= i_valid;
      o_written <= i_valid && do_write;
      o_tos <= do_write ? tos_new : i_tos;
      if (do_write && i_kind == dscp_remark_pkg::KIND_IPV4) begin
        o_csum <= csum_fix(i_csum, {8'h00, i_tos}, {8'h00, tos_new});
      end else begin
        o_csum <= i_csum;
      end
    end
  end

  a_other_untouched: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_valid && i_kind == dscp_remark_pkg::KIND_OTHER) |=> (!o_written && o_tos == $past(i_tos)))
    else $error("non-ip frame modified");
  a_egress_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_valid && !i_port_ena) |=> !o_written)
    else $error("write on disabled egress port");
  a_csum_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_valid && !do_write) |=> (o_csum == $past(i_csum)))
    else $error("checksum changed without rewrite");
endmodule : dscp_egress_write

// ==== hdl/dscp_remark_pkg.sv ====
// constants for the codepoint remark pipeline
package dscp_remark_pkg;
  localparam int NUM_PORTS = 8;
  localparam int PORT_W = 3;
  localparam int CP_W = 6;
  localparam int NUM_CP = 64;
  localparam int CLASS_W = 3;
  localparam int NUM_CLASS = 8;
  localparam int DP_W = 1;
  localparam int NUM_DP = 2;
  // codepoint field inside the traffic class / tos byte
  localparam int CP_LSB = 2;
  // ingress rewrite modes
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_ZERO = 2'h1;
  localparam logic [1:0] MODE_SELECT = 2'h2;
  localparam logic [1:0] MODE_ALL = 2'h3;
  // frame kinds
  localparam logic [1:0] KIND_OTHER = 2'h0;
  localparam logic [1:0] KIND_IPV4 = 2'h1;
  localparam logic [1:0] KIND_IPV6 = 2'h2;
  // apb byte addresses
  localparam logic [11:0] ADDR_MODE = 12'h000;
  localparam logic [11:0] ADDR_EGR_ENA = 12'h004;
  localparam logic [11:0] ADDR_SEL_LO = 12'h008;
  localparam logic [11:0] ADDR_SEL_HI = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_TRANS_CTL = 12'h014;
  localparam logic [11:0] ADDR_MAP_BASE = 12'h100;
  localparam logic [11:0] ADDR_DP0_BASE = 12'h200;
  localparam logic [11:0] ADDR_DP1_BASE = 12'h300;
  // reset values
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [7:0] RST_EGR_ENA = 8'h00;
  localparam logic [5:0] RST_CP = 6'h00;
endpackage : dscp_remark_pkg

// ==== hdl/dscp_remark_top.sv ====
// codepoint remark pipeline: apb registers, ingress decision, carry, egress
//
// Contract
// - two-bit rewrite mode per ingress port
// - mode 0: never rewrite (classifier override still rewrites)
// - mode 1: rewrite only codepoint zero (classifier override rewrites any codepoint)
// - mode 2: rewrite if codepoint enabled
// - mode 3: rewrite every frame
// - one enable bit per codepoint
// - new value from dp/class map
// - classifier codepoint overrides map value
// - decide at ingress, modify at egress
// - per egress port write enable
// - optional translate table for dp 0
// - separate translate table for dp 1
// - both sources share egress path
// - ipv4 checksum updated on rewrite
`timescale 1ns/1ps
module dscp_remark_top (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // ingress frame descriptor
  input wire logic i_in_valid,
  input wire logic [2:0] i_in_port,
  input wire logic [2:0] i_egr_port,
  input wire logic [1:0] i_in_kind,
  input wire logic [2:0] i_in_class,
  input wire logic i_in_dp,
  input wire logic [7:0] i_in_tos,
  input wire logic [15:0] i_in_csum,
  // advanced ingress classifier action
  input wire logic i_cls_hit,
  input wire logic i_cls_cp_ena,
  input wire logic [5:0] i_cls_cp,
  // egress result
  output logic o_out_valid,
  output logic [7:0] o_out_tos,
  output logic [15:0] o_out_csum,
  output logic o_out_written
);
  // register state
  logic [15:0] ingress_rewrite_mode;
  logic [7:0] egress_rewrite_enable;
  logic [63:0] codepoint_rewrite_enable;
  logic trans_ena;
  logic [5:0] class_to_codepoint_map [16];
  logic [5:0] dp0_translate_table [64];
  logic [5:0] dp1_translate_table [64];
  logic [15:0] frame_count;
  logic [15:0] write_count;

  // carried stage
  logic c_valid;
  logic [2:0] c_egr_port;
  logic [1:0] c_kind;
  logic c_dp;
  logic c_rewrite;
  logic [5:0] c_new_cp;
  logic [7:0] c_tos;
  logic [15:0] c_csum;

  // ingress decision
  logic [5:0] rx_cp;
  logic [1:0] port_mode;
  logic selected;
  logic [5:0] map_cp;
  logic cls_override;
  logic [5:0] next_cp;
  logic next_rewrite;

  logic apb_wr;
  logic apb_rd;
  logic [31:0] next_rdata;
  logic next_err;

  function automatic logic [1:0] mode_of(input logic [15:0] modes, input logic [2:0] port);
    mode_of = modes[{port, 1'b0} +: 2];
  endfunction : mode_of

  function automatic logic in_range(input logic [11:0] addr, input logic [11:0] base);
    in_range = (addr[11:8] == base[11:8]);
  endfunction : in_range

  function automatic logic map_hit(input logic [11:0] addr);
    map_hit = in_range(addr, dscp_remark_pkg::ADDR_MAP_BASE) && (addr[7:6] == 2'h0);
  endfunction : map_hit

  assign rx_cp = i_in_tos[7:dscp_remark_pkg::CP_LSB];
  assign port_mode = mode_of(ingress_rewrite_mode, i_in_port);

  always_comb begin
    case (port_mode)
      dscp_remark_pkg::MODE_NONE: selected = 1'b0;
      dscp_remark_pkg::MODE_ZERO: selected = (rx_cp == 6'h00);
      dscp_remark_pkg::MODE_SELECT: selected = codepoint_rewrite_enable[rx_cp];
      dscp_remark_pkg::MODE_ALL: selected = 1'b1;
      default: selected = 1'b0;
    endcase
  end

  assign map_cp = class_to_codepoint_map[{i_in_dp, i_in_class}];
  assign cls_override = i_cls_hit && i_cls_cp_ena;
  assign next_cp = cls_override ? i_cls_cp : map_cp;
  assign next_rewrite = selected || cls_override;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      c_valid <= 1'b0;
      c_egr_port <= 3'h0;
      c_kind <= dscp_remark_pkg::KIND_OTHER;
      c_dp <= 1'b0;
      c_rewrite <= 1'b0;
      c_new_cp <= dscp_remark_pkg::RST_CP;
      c_tos <= 8'h00;
      c_csum <= 16'h0000;
    end else if (i_ce) begin
      c_valid <= i_in_valid;
      c_egr_port <= i_egr_port;
      c_kind <= i_in_kind;
      c_dp <= i_in_dp;
      c_rewrite <= i_in_valid && next_rewrite;
      c_new_cp <= next_cp;
      c_tos <= i_in_tos;
      c_csum <= i_in_csum;
    end
  end

  // one egress path for both sources
  dscp_egress_write u_egress (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_port_ena(egress_rewrite_enable[c_egr_port]),
    .i_trans_ena(trans_ena),
    .i_dp0_cp(dp0_translate_table[c_new_cp]),
    .i_dp1_cp(dp1_translate_table[c_new_cp]),
    .i_valid(c_valid),
    .i_kind(c_kind),
    .i_dp(c_dp),
    .i_rewrite(c_rewrite),
    .i_new_cp(c_new_cp),
    .i_tos(c_tos),
    .i_csum(c_csum),
    .o_valid(o_out_valid),
    .o_tos(o_out_tos),
    .o_csum(o_out_csum),
    .o_written(o_out_written)
  );

  // apb access, one access phase, wait-free only while i_ce is high
  assign apb_wr = i_psel && i_penable && i_pwrite && i_ce;
  assign apb_rd = i_psel && !i_penable && !i_pwrite;
  assign o_pready = i_ce;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ingress_rewrite_mode <= dscp_remark_pkg::RST_MODE;
      egress_rewrite_enable <= dscp_remark_pkg::RST_EGR_ENA;
      codepoint_rewrite_enable <= 64'h0;
      trans_ena <= 1'b0;
    end else if (apb_wr) begin
      case (i_paddr)
        dscp_remark_pkg::ADDR_MODE: ingress_rewrite_mode <= i_pwdata[15:0];
        dscp_remark_pkg::ADDR_EGR_ENA: egress_rewrite_enable <= i_pwdata[7:0];
        dscp_remark_pkg::ADDR_SEL_LO: codepoint_rewrite_enable[31:0] <= i_pwdata;
        dscp_remark_pkg::ADDR_SEL_HI: codepoint_rewrite_enable[63:32] <= i_pwdata;
        dscp_remark_pkg::ADDR_TRANS_CTL: trans_ena <= i_pwdata[0];
        default: ;
      endcase
    end
  end

  // tables: no reset, software loads them
  always_ff @(posedge i_clk) begin
    if (apb_wr && i_paddr[1:0] == 2'h0) begin
      if (map_hit(i_paddr)) begin
        class_to_codepoint_map[i_paddr[5:2]] <= i_pwdata[5:0];
      end
      if (in_range(i_paddr, dscp_remark_pkg::ADDR_DP0_BASE)) begin
        dp0_translate_table[i_paddr[7:2]] <= i_pwdata[5:0];
      end
      if (in_range(i_paddr, dscp_remark_pkg::ADDR_DP1_BASE)) begin
        dp1_translate_table[i_paddr[7:2]] <= i_pwdata[5:0];
      end
    end
  end

  // status counters
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      frame_count <= 16'h0000;
      write_count <= 16'h0000;
    end else if (i_ce) begin
      if (o_out_valid) begin
        frame_count <= frame_count + 16'h0001;
      end
      if (o_out_written) begin
        write_count <= write_count + 16'h0001;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    if (map_hit(i_paddr)) begin
      next_rdata = {26'h0, class_to_codepoint_map[i_paddr[5:2]]};
    end else if (in_range(i_paddr, dscp_remark_pkg::ADDR_DP0_BASE)) begin
      next_rdata = {26'h0, dp0_translate_table[i_paddr[7:2]]};
    end else if (in_range(i_paddr, dscp_remark_pkg::ADDR_DP1_BASE)) begin
      next_rdata = {26'h0, dp1_translate_table[i_paddr[7:2]]};
    end else begin
      case (i_paddr)
        dscp_remark_pkg::ADDR_MODE: next_rdata = {16'h0, ingress_rewrite_mode};
        dscp_remark_pkg::ADDR_EGR_ENA: next_rdata = {24'h0, egress_rewrite_enable};
        dscp_remark_pkg::ADDR_SEL_LO: next_rdata = codepoint_rewrite_enable[31:0];
        dscp_remark_pkg::ADDR_SEL_HI: next_rdata = codepoint_rewrite_enable[63:32];
        dscp_remark_pkg::ADDR_STATUS: next_rdata = {write_count, frame_count};
        dscp_remark_pkg::ADDR_TRANS_CTL: next_rdata = {31'h0, trans_ena};
        default: next_err = 1'b1;
      endcase
    end
  end

  // read data captured in setup cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      if (apb_rd) begin
        o_prdata <= next_rdata;
      end
      if (i_psel && !i_penable) begin
        o_pslverr <= next_err;
      end
    end
  end

  a_mode_none: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && port_mode == dscp_remark_pkg::MODE_NONE && !cls_override) |=> !c_rewrite)
    else $error("mode none selected frame");

  a_mode_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && port_mode == dscp_remark_pkg::MODE_ZERO && !cls_override)
    |=> (c_rewrite == ($past(rx_cp) == 6'h00)))
    else $error("mode zero selection wrong");

  a_mode_select: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && port_mode == dscp_remark_pkg::MODE_SELECT && !cls_override)
    |=> (c_rewrite == $past(codepoint_rewrite_enable[rx_cp])))
    else $error("selected mode wrong");

  a_mode_all: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && port_mode == dscp_remark_pkg::MODE_ALL) |=> c_rewrite)
    else $error("mode all missed frame");

  a_map_value: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && !cls_override) |=> (c_new_cp == $past(map_cp)))
    else $error("map value not carried");

  a_cls_override: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && cls_override) |=> (c_rewrite && c_new_cp == $past(i_cls_cp)))
    else $error("classifier value not used");

  a_pipe_latency: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid) ##1 i_ce ##1 i_ce |-> o_out_valid)
    else $error("frame lost in pipeline");

  a_nonip_pass: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && i_in_kind == dscp_remark_pkg::KIND_OTHER) ##1 i_ce |=> !o_out_written)
    else $error("non-ip frame written");

  a_non_ip_kinds: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && i_in_kind != dscp_remark_pkg::KIND_IPV4 && i_in_kind != dscp_remark_pkg::KIND_IPV6)
    ##1 i_ce |=> !o_out_written)
    else $error("unknown kind frame written");

  a_mode_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (apb_wr && i_paddr == dscp_remark_pkg::ADDR_MODE) |=> (ingress_rewrite_mode == $past(i_pwdata[15:0])))
    else $error("mode write lost");

  a_sel_lo_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (apb_wr && i_paddr == dscp_remark_pkg::ADDR_SEL_LO) |=> (codepoint_rewrite_enable[31:0] == $past(i_pwdata)))
    else $error("low enable word lost");

  a_sel_hi_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (apb_wr && i_paddr == dscp_remark_pkg::ADDR_SEL_HI) |=> (codepoint_rewrite_enable[63:32] == $past(i_pwdata)))
    else $error("high enable word lost");

  a_egr_write: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (apb_wr && i_paddr == dscp_remark_pkg::ADDR_EGR_ENA) |=> (egress_rewrite_enable == $past(i_pwdata[7:0])))
    else $error("egress enable write lost");

  a_ipv6_csum: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid && i_in_kind == dscp_remark_pkg::KIND_IPV6) ##1 i_ce
    |=> (o_out_csum == $past(c_csum)))
    else $error("ipv6 checksum changed");

  a_idle_norewrite: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && !i_in_valid) |=> !c_rewrite)
    else $error("rewrite carried without frame");

  a_ce_freeze: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_ce |=> ($stable(c_valid) && $stable(c_rewrite) && $stable(c_new_cp)))
    else $error("carried stage moved while frozen");

  a_tos_carried: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_ce && i_in_valid) |=> (c_tos == $past(i_in_tos)))
    else $error("received byte altered at ingress");
endmodule : dscp_remark_top
